// file: core/i2cm_pkg.sv
// shared constants and types of the two-wire byte memory slave
package i2cm_pkg;

   // array geometry and write buffer depth
   localparam int          MEM_DEPTH     = 512;
   localparam int          ADDR_W        = 9;
   localparam int          DATA_W        = 8;
   localparam int          BUF_DEPTH     = 2;

   // slave address byte field positions
   localparam int          SA_TYPE_MSB   = 7;
   localparam int          SA_TYPE_LSB   = 4;
   localparam int          SA_SEL_MSB    = 3;
   localparam int          SA_SEL_LSB    = 2;
   localparam int          SA_PAGE_BIT   = 1;
   localparam int          SA_RW_BIT     = 0;

   // bits per byte on the wire and reset values
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
   localparam logic [3:0]  BITCNT_RST    = 4'h0;
   localparam logic [8:0]  ADDR_RST      = 9'h000;
   localparam logic [7:0]  BYTE_RST      = 8'h00;

   // device type nibble expected in the slave address; value is arbitrary
   localparam logic [3:0]  TYPE_ID_DEF   = 4'h5;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } i2cm_wr_t;

   typedef enum logic [3:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WORD,
      ST_WORD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RACK
   } i2cm_state_t;

endpackage

// file: core/i2cm_ram.sv
// 512 x 8 storage array with registered read data
`timescale 1ns/1ns
module i2cm_ram
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        en_i,
   input  wire logic                        we_i,
   input  wire logic [i2cm_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [i2cm_pkg::DATA_W-1:0] wdata_i,
   output logic      [i2cm_pkg::DATA_W-1:0] rdata_o
);

   logic [i2cm_pkg::DATA_W-1:0] mem_q [i2cm_pkg::MEM_DEPTH];
   logic [i2cm_pkg::DATA_W-1:0] rdata_q;

   always_ff @(posedge clk_i)
   begin
      if (en_i && we_i)
      begin
         mem_q[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_q <= i2cm_pkg::BYTE_RST;
      end
      else if (en_i && !we_i)
      begin
         rdata_q <= mem_q[addr_i];
      end
   end

   assign rdata_o = rdata_q;

endmodule // i2cm_ram

// file: core/i2cm_buf.sv
// two-entry write buffer with valid and ready on both sides
`timescale 1ns/1ns
module i2cm_buf
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               in_valid_i,
   output logic                    in_ready_o,
   input  wire i2cm_pkg::i2cm_wr_t in_data_i,
   output logic                    out_valid_o,
   input  wire logic               out_ready_i,
   output i2cm_pkg::i2cm_wr_t      out_data_o
);

   i2cm_pkg::i2cm_wr_t ent_q [i2cm_pkg::BUF_DEPTH];
   logic               wr_ptr_q;
   logic               rd_ptr_q;
   logic [1:0]         cnt_q;
   logic               push;
   logic               pop;

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = ent_q[rd_ptr_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         ent_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q    <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop)
         begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         case ({push, pop})
            2'b10:   cnt_q <= cnt_q + 2'h1;
            2'b01:   cnt_q <= cnt_q - 2'h1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

endmodule // i2cm_buf

// file: core/i2cm_slave.sv
// two-wire serial slave in front of a 512-byte nonvolatile byte array
//
// Functional notes
// - array of 512 bytes, 8 bits each, 9-bit byte address
// - each received data byte is written at once, no deferred write cycle
// - never busy after a write; next transaction accepted immediately
// - answer only when select bits in slave address match the select pins
// - unconnected select pins read as zero, pulled low inside; this model has no pull-down on device_select_pins_i
// - data line is only pulled low, otherwise released
// - outgoing bits change after clock falls, incoming sampled on clock rise
// - write-protect high blocks writes to every address
// - write-protect low or open allows writes to every address; wp_i has no pull-down in this model
// - serial clock up to 1 MHz, also 100 kHz and 400 kHz timings
// - slave address: select bits 3-2, page bit 1, read/write bit 0
// - write sends one word address joined with page bit into 9-bit latch
// - latch increments after each data byte before acknowledge, wraps to zero
// - read continues while master acknowledges, ends on missing acknowledge
`timescale 1ns/1ns
module i2cm_slave
#(
   parameter logic [3:0] TYPE_ID = i2cm_pkg::TYPE_ID_DEF
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   input  wire logic [1:0] device_select_pins_i,
   input  wire logic       wp_i
);

   i2cm_pkg::i2cm_state_t          state_q;
   logic [1:0]                     scl_sync_q;
   logic [1:0]                     sda_sync_q;
   logic [1:0]                     sel_sync0_q;
   logic [1:0]                     sel_sync1_q;
   logic [1:0]                     wp_sync_q;
   logic                           scl_d1_q;
   logic                           sda_d1_q;
   logic [3:0]                     bitcnt_q;
   logic [7:0]                     rx_q;
   logic [7:0]                     tx_q;
   logic [i2cm_pkg::ADDR_W-1:0]    addr_q;
   logic                           rw_q;
   logic                           mack_q;
   logic                           oe_n_q;
   logic                           rd_req_q;

   logic                           scl_s;
   logic                           sda_s;
   logic                           scl_rise;
   logic                           scl_fall;
   logic                           start_det;
   logic                           stop_det;
   logic                           byte_done;
   logic                           addr_match;
   logic                           wr_fire;

   i2cm_pkg::i2cm_wr_t             buf_in;
   i2cm_pkg::i2cm_wr_t             buf_out;
   logic                           buf_in_valid;
   logic                           buf_in_ready;
   logic                           buf_out_valid;
   logic                           buf_out_ready;
   logic                           mem_en;
   logic                           mem_we;
   logic [i2cm_pkg::ADDR_W-1:0]    mem_addr;
   logic [i2cm_pkg::DATA_W-1:0]    mem_rdata;

   // pin synchronisers, two stages each, plus an edge-detect stage behind the clock and data ones
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_d1_q   <= 1'b1;
         sda_d1_q   <= 1'b1;
         sel_sync0_q <= 2'h0;
         sel_sync1_q <= 2'h0;
         wp_sync_q   <= 2'h0;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_d1_q   <= scl_sync_q[1];
         sda_d1_q   <= sda_sync_q[1];
         sel_sync0_q <= device_select_pins_i;
         sel_sync1_q <= sel_sync0_q;
         wp_sync_q   <= {wp_sync_q[0], wp_i};
      end
   end

   assign scl_s     = scl_sync_q[1];
   assign sda_s     = sda_sync_q[1];
   // edges seen at 20 MHz; a 1 MHz clock still gives several samples per phase
   assign scl_rise  = scl_s && !scl_d1_q;
   assign scl_fall  = !scl_s && scl_d1_q;
   assign start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
   assign stop_det  = scl_s && scl_d1_q && !sda_d1_q && sda_s;
   assign byte_done = scl_fall && (bitcnt_q == i2cm_pkg::BITS_PER_BYTE);

   assign addr_match =
      (rx_q[i2cm_pkg::SA_TYPE_MSB:i2cm_pkg::SA_TYPE_LSB] == TYPE_ID) &&
      (rx_q[i2cm_pkg::SA_SEL_MSB:i2cm_pkg::SA_SEL_LSB] == sel_sync1_q);

   // a data byte is taken only if the buffer has room; otherwise it is refused
   assign wr_fire = (state_q == i2cm_pkg::ST_WDATA) && byte_done && buf_in_ready;

   // protocol state and bit counter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q  <= i2cm_pkg::ST_IDLE;
         bitcnt_q <= i2cm_pkg::BITCNT_RST;
         mack_q   <= 1'b0;
      end
      else if (start_det)
      begin
         state_q  <= i2cm_pkg::ST_ADDR;
         bitcnt_q <= i2cm_pkg::BITCNT_RST;
      end
      else if (stop_det)
      begin
         state_q  <= i2cm_pkg::ST_IDLE;
      end
      else
      begin
         if (scl_rise && bitcnt_q != i2cm_pkg::BITS_PER_BYTE)
         begin
            bitcnt_q <= bitcnt_q + 4'h1;
         end
         if (scl_rise && state_q == i2cm_pkg::ST_RACK)
         begin
            mack_q <= !sda_s;
         end
         if (scl_fall)
         begin
            case (state_q)
               i2cm_pkg::ST_ADDR:
               begin
                  if (byte_done)
                  begin
                     state_q <= addr_match ? i2cm_pkg::ST_ADDR_ACK : i2cm_pkg::ST_IDLE;
                  end
               end
               i2cm_pkg::ST_ADDR_ACK:
               begin
                  state_q  <= rw_q ? i2cm_pkg::ST_RDATA : i2cm_pkg::ST_WORD;
                  bitcnt_q <= i2cm_pkg::BITCNT_RST;
               end
               i2cm_pkg::ST_WORD:
               begin
                  if (byte_done)
                  begin
                     state_q <= i2cm_pkg::ST_WORD_ACK;
                  end
               end
               i2cm_pkg::ST_WDATA:
               begin
                  if (byte_done)
                  begin
                     state_q <= buf_in_ready ? i2cm_pkg::ST_WDATA_ACK : i2cm_pkg::ST_IDLE;
                  end
               end
               i2cm_pkg::ST_WORD_ACK, i2cm_pkg::ST_WDATA_ACK:
               begin
                  // no busy phase: the next byte or transaction follows at once
                  state_q  <= i2cm_pkg::ST_WDATA;
                  bitcnt_q <= i2cm_pkg::BITCNT_RST;
               end
               i2cm_pkg::ST_RDATA:
               begin
                  if (byte_done)
                  begin
                     state_q <= i2cm_pkg::ST_RACK;
                  end
               end
               i2cm_pkg::ST_RACK:
               begin
                  state_q  <= mack_q ? i2cm_pkg::ST_RDATA : i2cm_pkg::ST_IDLE;
                  bitcnt_q <= i2cm_pkg::BITCNT_RST;
               end
               default:
               begin
                  state_q <= i2cm_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // incoming bits sampled on the clock rise, msb first
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_q <= i2cm_pkg::BYTE_RST;
      end
      else if (scl_rise)
      begin
         rx_q <= {rx_q[6:0], sda_s};
      end
   end

   // address latch and transfer direction
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         addr_q <= i2cm_pkg::ADDR_RST;
         rw_q   <= 1'b0;
      end
      else if (!start_det && !stop_det)
      begin
         if (state_q == i2cm_pkg::ST_ADDR && byte_done && addr_match)
         begin
            addr_q[i2cm_pkg::ADDR_W-1] <= rx_q[i2cm_pkg::SA_PAGE_BIT];
            rw_q                       <= rx_q[i2cm_pkg::SA_RW_BIT];
         end
         if (state_q == i2cm_pkg::ST_WORD && byte_done)
         begin
            addr_q[7:0] <= rx_q;
         end
         // advance before the acknowledge; 9-bit add wraps top to zero
         if (wr_fire || (state_q == i2cm_pkg::ST_RDATA && byte_done))
         begin
            addr_q <= addr_q + 9'h001;
         end
      end
   end

   // data line: bits change only after a clock fall, a one means released
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         oe_n_q <= 1'b1;
         tx_q   <= i2cm_pkg::BYTE_RST;
      end
      else if (start_det || stop_det)
      begin
         oe_n_q <= 1'b1;
      end
      else if (scl_fall)
      begin
         case (state_q)
            i2cm_pkg::ST_ADDR:
            begin
               oe_n_q <= !(byte_done && addr_match);
            end
            i2cm_pkg::ST_ADDR_ACK, i2cm_pkg::ST_RACK:
            begin
               if ((state_q == i2cm_pkg::ST_ADDR_ACK) ? rw_q : mack_q)
               begin
                  oe_n_q <= mem_rdata[7];
                  tx_q   <= {mem_rdata[6:0], 1'b0};
               end
               else
               begin
                  oe_n_q <= 1'b1;
               end
            end
            i2cm_pkg::ST_WORD:
            begin
               oe_n_q <= !byte_done;
            end
            i2cm_pkg::ST_WDATA:
            begin
               // protected bytes are still acknowledged
               oe_n_q <= !wr_fire;
            end
            i2cm_pkg::ST_RDATA:
            begin
               // released after bit 0 so the master can acknowledge
               oe_n_q <= byte_done || tx_q[7];
               tx_q   <= {tx_q[6:0], 1'b0};
            end
            default:
            begin
               oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // array read requests: one at read start, one per master acknowledge
   always_ff @(posedge clk_i)
   begin
      rd_req_q <= !rst_i && !start_det && !stop_det &&
                  ((state_q == i2cm_pkg::ST_ADDR && byte_done && addr_match &&
                    rx_q[i2cm_pkg::SA_RW_BIT]) ||
                   (state_q == i2cm_pkg::ST_RACK && scl_rise && !sda_s));
   end

   // open drain: only ever pulls low
   assign sda_o      = 1'b0;
   assign sda_oe_n_o = oe_n_q;

   // write path: protected bytes never enter the buffer
   assign buf_in.addr   = addr_q;
   assign buf_in.data   = rx_q;
   assign buf_in_valid  = wr_fire && !wp_sync_q[1];

   // reads take the array port first and stall the buffer drain
   assign buf_out_ready = !rd_req_q;
   assign mem_en        = rd_req_q || buf_out_valid;
   assign mem_we        = !rd_req_q && buf_out_valid;
   assign mem_addr      = rd_req_q ? addr_q : buf_out.addr;

   i2cm_buf u_buf
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (buf_in_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (buf_in),
      .out_valid_o (buf_out_valid),
      .out_ready_i (buf_out_ready),
      .out_data_o  (buf_out)
   );

   i2cm_ram u_ram
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (mem_en),
      .we_i    (mem_we),
      .addr_i  (mem_addr),
      .wdata_i (buf_out.data),
      .rdata_o (mem_rdata)
   );

endmodule // i2cm_slave

// file: bench/i2cm_props.sv
// assertions watching the serial slave's ports
`timescale 1ns/1ns
module i2cm_props
#(
   parameter logic [3:0] TYPE_ID = i2cm_pkg::TYPE_ID_DEF
)
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_n_o,
   input wire logic [1:0] device_select_pins_i,
   input wire logic       wp_i
);
   logic       scl_p_q;
   logic       sda_p_q;
   logic       seen_q;
   logic       first_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   wire        start_w = scl_i & scl_p_q & sda_p_q & ~sda_i;
   wire        rise_w  = scl_i & ~scl_p_q;
   wire        slot_w  = rise_w & first_q & (cnt_q == 4'h8);
   wire        hit_w   = (sh_q[7:2] == {TYPE_ID, device_select_pins_i});
   always_ff @(posedge clk_i)
   begin
      scl_p_q <= scl_i;
      sda_p_q <= sda_i;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         seen_q <= 1'b0;
      else if (start_w)
         seen_q <= 1'b1;
   end
   // decode the first byte after each start to find the address acknowledge slot
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         first_q <= 1'b0;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
      end
      else if (start_w)
      begin
         first_q <= 1'b1;
         cnt_q   <= 4'h0;
      end
      else if (rise_w && first_q)
      begin
         if (cnt_q == 4'h8)
            first_q <= 1'b0;
         else
         begin
            cnt_q <= cnt_q + 4'h1;
            sh_q  <= {sh_q[6:0], sda_i};
         end
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_sda_low_only: assert property (sda_o == 1'b0)
      else $error("data output value is not low");
   a_reset_release: assert property ($fell(rst_i) |-> sda_oe_n_o [*4])
      else $error("data line driven right after reset");
   a_idle_quiet: assert property (!seen_q |-> sda_oe_n_o)
      else $error("data line driven before any start");
   a_drive_scl_low: assert property ($fell(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
      else $error("data drive began outside clock low phase");
   a_release_scl_low: assert property ($rose(sda_oe_n_o) |-> !scl_i)
      else $error("data released while clock high");
   a_ack_holds: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
      else $error("low drive too short");
   a_match_ack: assert property (slot_w && hit_w |-> !sda_oe_n_o)
      else $error("matching address not acknowledged");
   a_mismatch_nack: assert property (slot_w && !hit_w |-> sda_oe_n_o)
      else $error("foreign address acknowledged");
   c_match: cover property (slot_w && hit_w && !sda_oe_n_o);
   c_mismatch: cover property (slot_w && !hit_w && sda_oe_n_o);
   c_protected_ack: cover property (wp_i && $fell(sda_oe_n_o));
endmodule // i2cm_props

// file: bench/i2cm_master.sv
// two-wire bus master model, pulls data low and drives the clock
`timescale 1ns/1ns
module i2cm_master
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   initial
   begin
      scl_o      = 1'b1;
      sda_pull_o = 1'b0;
   end
   // quarter period of 5 clocks gives a 1 MHz bus clock
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic start_cond();
      sda_pull_o <= 1'b0;
      wait_clk(5);
      scl_o <= 1'b1;
      wait_clk(5);
      sda_pull_o <= 1'b1;
      wait_clk(5);
      scl_o <= 1'b0;
      wait_clk(5);
   endtask
   task automatic stop_cond();
      sda_pull_o <= 1'b1;
      wait_clk(5);
      scl_o <= 1'b1;
      wait_clk(5);
      sda_pull_o <= 1'b0;
      wait_clk(5);
   endtask
   // data set mid low phase, sampled mid high phase, msb first
   task automatic bit_io(input logic b, output logic r);
      sda_pull_o <= !b;
      wait_clk(5);
      scl_o <= 1'b1;
      wait_clk(5);
      r = sda_i;
      wait_clk(5);
      scl_o <= 1'b0;
      wait_clk(5);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!more, r);
   endtask
endmodule // i2cm_master

// file: bench/tb.sv
// self-checking bench for the two-wire byte memory slave
`timescale 1ns/1ns
module tb;
   logic       clk_i;
   logic       rst_i;
   logic       scl;
   logic       m_pull;
   logic       sda_o;
   logic       sda_oe_n_o;
   logic [1:0] pins;
   logic       wp;
   logic       ack;
   logic [7:0] rd;
   int         fail_count;
   int         samples_checked;
   // pull-up wins unless a party pulls low
   wire        sda = (sda_oe_n_o | sda_o) & ~m_pull;
   i2cm_slave dut_u (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
                     .sda_oe_n_o(sda_oe_n_o), .device_select_pins_i(pins), .wp_i(wp));
   i2cm_master m_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(m_pull));
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] sa(input logic [1:0] s, input logic pg, input logic rw);
      return {i2cm_pkg::TYPE_ID_DEF, s, pg, rw};
   endfunction
   task automatic addr_w(input logic [8:0] a);
      m_u.start_cond();
      m_u.wr_byte(sa(pins, a[8], 1'b0), ack);
      chk(ack, 8'h01);
      m_u.wr_byte(a[7:0], ack);
      chk(ack, 8'h01);
   endtask
   task automatic wdata(input logic [7:0] d);
      m_u.wr_byte(d, ack);
      chk(ack, 8'h01);
   endtask
   task automatic rd_start(input logic pg);
      m_u.start_cond();
      m_u.wr_byte(sa(pins, pg, 1'b1), ack);
      chk(ack, 8'h01);
   endtask
   task automatic rbyte(input logic [7:0] exp, input logic more);
      m_u.rd_byte(more, rd);
      chk(rd, exp);
   endtask
   task automatic t_write_wrap();
      pins <= 2'b00;
      wp   <= 1'b0;
      addr_w(9'h1FE);
      wdata(8'h11);
      wdata(8'h22);
      wdata(8'h33);
      wdata(8'h44);
      m_u.stop_cond();
      addr_w(9'h1FE);
      rd_start(1'b1);
      rbyte(8'h11, 1'b1);
      rbyte(8'h22, 1'b0);
      m_u.stop_cond();
      rd_start(1'b0);
      rbyte(8'h33, 1'b0);
      m_u.stop_cond();
   endtask
   task automatic t_protect();
      wp <= 1'b1;
      addr_w(9'h1FF);
      wdata(8'h99);
      wdata(8'h98);
      m_u.stop_cond();
      wp <= 1'b0;
      rd_start(1'b0);
      rbyte(8'h44, 1'b0);
      m_u.stop_cond();
      addr_w(9'h1FF);
      rd_start(1'b1);
      rbyte(8'h22, 1'b0);
      m_u.stop_cond();
      rd_start(1'b0);
      rbyte(8'h33, 1'b0);
      m_u.stop_cond();
   endtask
   task automatic t_select();
      pins <= 2'b10;
      for (int s = 0; s < 4; s++)
      begin
         m_u.start_cond();
         m_u.wr_byte(sa(2'(s), 1'b0, 1'b0), ack);
         chk(ack, (s == 2) ? 8'h01 : 8'h00);
         m_u.stop_cond();
      end
      m_u.start_cond();
      m_u.wr_byte({i2cm_pkg::TYPE_ID_DEF ^ 4'h3, 4'h8}, ack);
      chk(ack, 8'h00);
      m_u.stop_cond();
   endtask
   initial
   begin
      fail_count      = 0;
      samples_checked = 0;
      rst_i           = 1'b1;
      pins            = 2'b00;
      wp              = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_write_wrap();
      t_protect();
      t_select();
      give_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule // tb
bind i2cm_slave i2cm_props #(.TYPE_ID(TYPE_ID)) props_u
(
   .clk_i(clk_i),
   .rst_i(rst_i),
   .scl_i(scl_i),
   .sda_i(sda_i),
   .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o),
   .device_select_pins_i(device_select_pins_i),
   .wp_i(wp_i)
);
